// ### core/htf_map.svh
// numeric map of the host transport frame decoder: codes, fields, sizes
`ifndef HTF_MAP_SVH
`define HTF_MAP_SVH

`define HTF_WORD_W        16
`define HTF_PAGE_W        8
`define HTF_OFF_W         7
`define HTF_ADDR_W        15
`define HTF_FIFO_DEPTH    32
`define HTF_DIRECT_LIMIT  7'h78
`define HTF_UB_START_RD   8'hf8
`define HTF_UB_START_WR   8'hf9
`define HTF_UB_CONT_RD    8'hfa
`define HTF_UB_CONT_WR    8'hfb
`define HTF_UB_CFG        8'hfd
`define HTF_UB_SEL        8'hfe
`define HTF_UB_NOP        8'hff
`define HTF_CFG_W         5
`define HTF_CFG_RST       5'h00
`define HTF_PAGE_RST      8'h00
`define HTF_ADDR_RST      15'h0000
`define HTF_OFF_ZERO      7'h00
`define HTF_DIR_PAGE      8'h00
`define HTF_SEL_SERIAL    3'h4

`endif

// ### core/htf_pkg.sv
// types and command decoding shared by both ends of the transport link
`default_nettype none
`include "htf_map.svh"

package htf_pkg;

	typedef enum logic [2:0] {
		HTF_K_PAGED,
		HTF_K_DIRECT,
		HTF_K_START,
		HTF_K_CONT,
		HTF_K_CFG,
		HTF_K_SEL,
		HTF_K_NOP,
		HTF_K_RSVD
	} htf_kind_t;

	typedef struct packed {
		htf_kind_t                kind;
		logic                     wr;
		logic [7:0]               len;
		logic [`HTF_OFF_W-1:0]    off;
		logic [7:0]               arg;
	} htf_cmd_t;

	// split a command word into kind, direction, length and offset
	function automatic htf_cmd_t htf_decode(input logic [15:0] w);
		htf_cmd_t c;
		c.kind = HTF_K_RSVD;
		c.wr   = w[7];
		c.len  = {1'b0, w[6:0]};
		c.off  = w[14:8];
		c.arg  = w[7:0];
		if (!w[15]) begin
			c.kind = HTF_K_PAGED;
		end else if (w[14:8] < `HTF_DIRECT_LIMIT) begin
			c.kind = HTF_K_DIRECT;
		end else begin
			case (w[15:8])
				`HTF_UB_START_RD, `HTF_UB_START_WR: begin
					c.kind = HTF_K_START;
					c.wr   = w[8];
					c.len  = w[7:0];
				end
				`HTF_UB_CONT_RD, `HTF_UB_CONT_WR: begin
					c.kind = HTF_K_CONT;
					c.wr   = w[8];
					c.len  = w[7:0];
				end
				`HTF_UB_CFG: c.kind = HTF_K_CFG;
				`HTF_UB_SEL: c.kind = HTF_K_SEL;
				`HTF_UB_NOP: c.kind = HTF_K_NOP;
				default:     c.kind = HTF_K_RSVD;
			endcase
		end
		return c;
	endfunction

	// true for commands that carry data words
	function automatic logic htf_has_data(input htf_kind_t k);
		return (k == HTF_K_PAGED) || (k == HTF_K_DIRECT) ||
		       (k == HTF_K_START) || (k == HTF_K_CONT);
	endfunction

endpackage

`default_nettype wire

// ### core/htf_link_if.sv
// word link between host end and device end
`timescale 1ns/1ps
`default_nettype none

interface htf_link_if;
	logic        h2d_valid;
	logic        h2d_ready;
	logic [15:0] h2d_word;
	logic        d2h_valid;
	logic        d2h_ready;
	logic [15:0] d2h_word;

	modport dev (
		input  h2d_valid,
		output h2d_ready,
		input  h2d_word,
		output d2h_valid,
		input  d2h_ready,
		output d2h_word
	);

	modport host (
		output h2d_valid,
		input  h2d_ready,
		output h2d_word,
		input  d2h_valid,
		output d2h_ready,
		input  d2h_word
	);
endinterface

`default_nettype wire

// ### core/htf_dev_end.sv
// device end: the transport frame decoder and its memory strobes
`timescale 1ns/1ps
`default_nettype none
`include "htf_map.svh"

module htf_dev_end
	import htf_pkg::*;
(
	input  wire logic                    SYS_CLK,
	input  wire logic                    SRST,
	htf_link_if.dev                      LINK,
	input  wire logic [2:0]              PORT_SEL,
	output logic [`HTF_ADDR_W-1:0]       MEM_ADDR,
	output logic                         MEM_DIRECT,
	output logic                         MEM_WE,
	output logic                         MEM_RE,
	output logic [`HTF_WORD_W-1:0]       MEM_WDATA,
	input  wire logic [`HTF_WORD_W-1:0]  MEM_RDATA,
	output logic [`HTF_PAGE_W-1:0]       PAGE,
	output logic [`HTF_CFG_W-1:0]        CFG_OPTS,
	output logic [2:0]                   PORT_MODE,
	output logic                         PORT_SERIAL,
	output logic                         PORT_BAD
);
	typedef enum logic [1:0] {
		S_CMD  = 2'b01,
		S_XFER = 2'b10
	} htf_dstate_t;

	htf_dstate_t                  state_r;
	htf_dstate_t                  state_nxt;
	htf_cmd_t                     cmd;
	logic [`HTF_PAGE_W-1:0]       page_r;
	logic [`HTF_CFG_W-1:0]        cfg_r;
	logic [`HTF_ADDR_W-1:0]       addr_r;
	logic [`HTF_ADDR_W-1:0]       str_next_r;
	logic                         lin_r;
	logic                         dir_r;
	logic                         wr_r;
	logic [7:0]                   rem_r;
	logic                         take_cmd;
	logic                         take_wr;
	logic                         issue_rd;
	logic                         step;
	logic                         f_in_ready;
	logic                         mem_we_r;
	logic                         mem_re_r;
	logic                         mem_dir_r;
	logic [`HTF_ADDR_W-1:0]       mem_addr_r;
	logic [`HTF_WORD_W-1:0]       mem_wdata_r;
	logic [2:0]                   ps_s1_r;
	logic [2:0]                   ps_s2_r;
	logic [2:0]                   ps_cap_r;
	logic                         ps_done_r;

	// next address: streams run on through pages, offset accesses wrap
	function automatic logic [`HTF_ADDR_W-1:0] next_addr(
		input logic [`HTF_ADDR_W-1:0] a,
		input logic                   lin
	);
		logic [`HTF_OFF_W-1:0] o;
		o = a[`HTF_OFF_W-1:0] + 1'b1;
		return lin ? `HTF_ADDR_W'(a + 1'b1)
		           : {a[`HTF_ADDR_W-1:`HTF_OFF_W], o};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// word handshakes; the link is word level whatever port is strapped
	assign cmd      = htf_decode(LINK.h2d_word);
	assign take_cmd = (state_r == S_CMD) && LINK.h2d_valid;
	assign take_wr  = (state_r == S_XFER) && wr_r && LINK.h2d_valid;
	// one read every other cycle keeps the fifo room check exact
	assign issue_rd = (state_r == S_XFER) && !wr_r && !mem_re_r &&
	                  f_in_ready;
	assign step     = take_wr || issue_rd;
	assign LINK.h2d_ready = (state_r == S_CMD) ||
	                        ((state_r == S_XFER) && wr_r);

	// frame sequencing: data commands open a transfer of len+1 words
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_CMD: begin
				if (take_cmd && htf_has_data(cmd.kind)) begin
					state_nxt = S_XFER;
				end
			end
			S_XFER: begin
				if (step && (rem_r == 8'h00)) begin
					state_nxt = S_CMD;
				end
			end
			default: state_nxt = S_CMD;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_r <= S_CMD;
		end else begin
			state_r <= state_nxt;
		end
	end

	// transfer address, direction and remaining count
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			addr_r <= `HTF_ADDR_RST;
			lin_r  <= 1'b0;
			dir_r  <= 1'b0;
			wr_r   <= 1'b0;
			rem_r  <= 8'h00;
		end else if (take_cmd && htf_has_data(cmd.kind)) begin
			wr_r  <= cmd.wr;
			rem_r <= cmd.len;
			case (cmd.kind)
				HTF_K_PAGED: begin
					addr_r <= {page_r, cmd.off};
					lin_r  <= 1'b0;
					dir_r  <= 1'b0;
				end
				HTF_K_DIRECT: begin
					addr_r <= {`HTF_DIR_PAGE, cmd.off};
					lin_r  <= 1'b0;
					dir_r  <= 1'b1;
				end
				HTF_K_START: begin
					addr_r <= {page_r, `HTF_OFF_ZERO};
					lin_r  <= 1'b1;
					dir_r  <= 1'b0;
				end
				default: begin
					addr_r <= str_next_r;
					lin_r  <= 1'b1;
					dir_r  <= 1'b0;
				end
			endcase
		end else if (step) begin
			addr_r <= next_addr(addr_r, lin_r);
			rem_r  <= rem_r - 8'h01;
		end
	end

	// stream resume point, moved only by start or continue words
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			str_next_r <= `HTF_ADDR_RST;
		end else if (step && lin_r) begin
			str_next_r <= next_addr(addr_r, 1'b1);
		end
	end

	// page and option registers; nop and reserved codes change nothing
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			page_r <= `HTF_PAGE_RST;
			cfg_r  <= `HTF_CFG_RST;
		end else if (take_cmd) begin
			if (cmd.kind == HTF_K_SEL) begin
				page_r <= cmd.arg;
			end
			if (cmd.kind == HTF_K_CFG) begin
				cfg_r <= cmd.arg[`HTF_CFG_W-1:0];
			end
		end
	end

	// memory strobes registered so the internal bus sees clean pulses
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			mem_we_r    <= 1'b0;
			mem_re_r    <= 1'b0;
			mem_dir_r   <= 1'b0;
			mem_addr_r  <= `HTF_ADDR_RST;
			mem_wdata_r <= '0;
		end else begin
			mem_we_r <= take_wr;
			mem_re_r <= issue_rd;
			if (step) begin
				mem_addr_r <= addr_r;
				mem_dir_r  <= dir_r;
			end
			if (take_wr) begin
				mem_wdata_r <= LINK.h2d_word;
			end
		end
	end

	// read data is caught in the strobe cycle and queued for the host
	htf_fifo #(
		.W (`HTF_WORD_W),
		.D (`HTF_FIFO_DEPTH)
	) u_rd_fifo (
		.clk       (SYS_CLK),
		.srst      (SRST),
		.in_valid  (mem_re_r),
		.in_ready  (f_in_ready),
		.in_data   (MEM_RDATA),
		.out_valid (LINK.d2h_valid),
		.out_ready (LINK.d2h_ready),
		.out_data  (LINK.d2h_word)
	);

	////////////////////////////////////////////////////////////////////////
	// strap pins: two flops, then caught once after reset release
	always_ff @(posedge SYS_CLK) begin
		ps_s1_r <= PORT_SEL;
		ps_s2_r <= ps_s1_r;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			ps_cap_r  <= 3'h0;
			ps_done_r <= 1'b0;
		end else if (!ps_done_r) begin
			ps_cap_r  <= ps_s2_r;
			ps_done_r <= 1'b1;
		end
	end

	assign PORT_MODE   = ps_cap_r;
	assign PORT_SERIAL = (ps_cap_r == `HTF_SEL_SERIAL);
	assign PORT_BAD    = (ps_cap_r > `HTF_SEL_SERIAL);
	assign MEM_ADDR    = mem_addr_r;
	assign MEM_DIRECT  = mem_dir_r;
	assign MEM_WE      = mem_we_r;
	assign MEM_RE      = mem_re_r;
	assign MEM_WDATA   = mem_wdata_r;
	assign PAGE        = page_r;
	assign CFG_OPTS    = cfg_r;
endmodule

`default_nettype wire

// ### core/htf_host_end.sv
// host end framer, and the word fifo the device end queues reads in
`timescale 1ns/1ps
`default_nettype none
`include "htf_map.svh"

module htf_host_end
	import htf_pkg::*;
(
	input  wire logic                    SYS_CLK,
	input  wire logic                    SRST,
	htf_link_if.host                     LINK,
	input  wire logic                    CMD_VALID,
	output logic                         CMD_READY,
	input  wire logic [`HTF_WORD_W-1:0]  CMD_WORD,
	output logic                         CMD_ERR,
	input  wire logic                    WR_VALID,
	output logic                         WR_READY,
	input  wire logic [`HTF_WORD_W-1:0]  WR_DATA,
	output logic                         RD_VALID,
	input  wire logic                    RD_READY,
	output logic [`HTF_WORD_W-1:0]       RD_DATA,
	output logic                         BUSY
);
	typedef enum logic [2:0] {
		H_CMD = 3'b001,
		H_WR  = 3'b010,
		H_RD  = 3'b100
	} htf_hstate_t;

	htf_hstate_t               state_r;
	htf_cmd_t                  cmd;
	logic [7:0]                rem_r;
	logic                      out_v_r;
	logic [`HTF_WORD_W-1:0]    out_w_r;
	logic                      rd_v_r;
	logic [`HTF_WORD_W-1:0]    rd_d_r;
	logic                      err_r;
	logic                      bad;
	logic                      take_cmd;
	logic                      take_wr;
	logic                      take_rd;

	assign cmd = htf_decode(CMD_WORD);
	// reserved codes and over-long direct lengths never go out
	assign bad = (cmd.kind == HTF_K_RSVD) ||
	             ((cmd.kind == HTF_K_DIRECT) &&
	              (cmd.len[6:0] >= `HTF_DIRECT_LIMIT));

	assign CMD_READY = (state_r == H_CMD) && !out_v_r;
	assign WR_READY  = (state_r == H_WR) && !out_v_r;
	assign take_cmd  = CMD_VALID && CMD_READY;
	assign take_wr   = WR_VALID && WR_READY;
	assign take_rd   = (state_r == H_RD) && LINK.d2h_valid && !rd_v_r;
	assign LINK.d2h_ready = (state_r == H_RD) && !rd_v_r;

	// frame state: count len+1 data words after a data command
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_r <= H_CMD;
			rem_r   <= 8'h00;
		end else begin
			case (state_r)
				H_CMD: begin
					if (take_cmd && !bad && htf_has_data(cmd.kind)) begin
						rem_r   <= cmd.len;
						state_r <= cmd.wr ? H_WR : H_RD;
					end
				end
				H_WR: begin
					if (take_wr) begin
						rem_r <= rem_r - 8'h01;
						if (rem_r == 8'h00) begin
							state_r <= H_CMD;
						end
					end
				end
				H_RD: begin
					if (take_rd) begin
						rem_r <= rem_r - 8'h01;
						if (rem_r == 8'h00) begin
							state_r <= H_CMD;
						end
					end
				end
				default: state_r <= H_CMD;
			endcase
		end
	end

	// single output word register; half rate, but data is always a flop
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			out_v_r <= 1'b0;
			out_w_r <= '0;
		end else if ((take_cmd && !bad) || take_wr) begin
			out_v_r <= 1'b1;
			out_w_r <= take_cmd ? CMD_WORD : WR_DATA;
		end else if (LINK.h2d_ready) begin
			out_v_r <= 1'b0;
		end
	end

	// returned read words and the refusal pulse
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			rd_v_r <= 1'b0;
			rd_d_r <= '0;
			err_r  <= 1'b0;
		end else begin
			err_r <= take_cmd && bad;
			if (take_rd) begin
				rd_v_r <= 1'b1;
				rd_d_r <= LINK.d2h_word;
			end else if (RD_READY) begin
				rd_v_r <= 1'b0;
			end
		end
	end

	assign LINK.h2d_valid = out_v_r;
	assign LINK.h2d_word  = out_w_r;
	assign RD_VALID       = rd_v_r;
	assign RD_DATA        = rd_d_r;
	assign CMD_ERR        = err_r;
	assign BUSY           = (state_r != H_CMD) || out_v_r;
endmodule

////////////////////////////////////////////////////////////////////////////////

module htf_fifo #(
	parameter int W = 16,
	parameter int D = 32
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	// advance a pointer, wrapping at the depth
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready  = (cnt_r != (AW + 1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage, no reset needed on the data array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk) begin
		if (srst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= bump(wp_r);
			end
			if (pop) begin
				rp_r <= bump(rp_r);
			end
			cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

`default_nettype wire

// ### test/htf_link_props.sv
// checker for the word link between host end and device end
`timescale 1ns/1ps
`default_nettype none

module htf_link_props
	import htf_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	input  wire logic        h2d_valid,
	input  wire logic        h2d_ready,
	input  wire logic [15:0] h2d_word,
	input  wire logic        d2h_valid,
	input  wire logic        d2h_ready,
	input  wire logic [15:0] d2h_word
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	logic       take, pop, is_cmd, acc, rd;
	logic [8:0] cnt;
	logic [8:0] wr_rem_r;
	logic [8:0] rd_rem_r;

	////////////////////////////////////////////////////////////////////////
	// frame tracking: a word outside any data phase is a command
	assign take   = h2d_valid && h2d_ready;
	assign pop    = d2h_valid && d2h_ready;
	assign is_cmd = take && (wr_rem_r == 9'h000) && (rd_rem_r == 9'h000);

	// offset accesses carry 7-bit length, streams 8-bit
	always_comb begin
		acc = 1'b1;
		rd  = ~h2d_word[7];
		cnt = {2'b00, h2d_word[6:0]} + 9'h001;
		if (h2d_word[15] && (h2d_word[14:8] >= 7'h78)) begin
			acc = (h2d_word[15:10] == 6'h3e);
			rd  = ~h2d_word[8];
			cnt = {1'b0, h2d_word[7:0]} + 9'h001;
		end
	end

	// write words still owed by the host
	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			wr_rem_r <= 9'h000;
		else if (is_cmd && acc && !rd)
			wr_rem_r <= cnt;
		else if (take && (wr_rem_r != 9'h000))
			wr_rem_r <= wr_rem_r - 9'h001;
	end

	// read words still owed by the device
	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			rd_rem_r <= 9'h000;
		else if (is_cmd && acc && rd)
			rd_rem_r <= cnt;
		else if (pop && (rd_rem_r != 9'h000))
			rd_rem_r <= rd_rem_r - 9'h001;
	end

	////////////////////////////////////////////////////////////////////////
	property p_h2d_hold;
		h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_word);
	endproperty
	a_h2d_hold: assert property (p_h2d_hold)
		else $error("host word changed before taken");
	property p_d2h_hold;
		d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_word);
	endproperty
	a_d2h_hold: assert property (p_d2h_hold)
		else $error("read word changed before taken");
	property p_rst_dev;
		$fell(SRST) |-> !d2h_valid && h2d_ready;
	endproperty
	a_rst_dev: assert property (p_rst_dev)
		else $error("device link not idle after reset");
	property p_rst_host;
		$fell(SRST) |-> !h2d_valid;
	endproperty
	a_rst_host: assert property (p_rst_host)
		else $error("host offers a word right after reset");
	property p_rd_ans;
		is_cmd && acc && rd |-> ##[2:8] d2h_valid;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("read command got no answer");
	property p_no_extra;
		rd_rem_r == 9'h000 |-> !d2h_valid;
	endproperty
	a_no_extra: assert property (p_no_extra)
		else $error("read word beyond frame length");
	property p_wr_rdy;
		wr_rem_r != 9'h000 |-> h2d_ready;
	endproperty
	a_wr_rdy: assert property (p_wr_rdy)
		else $error("device stalls write data");
	property p_half;
		take |=> !h2d_valid;
	endproperty
	a_half: assert property (p_half)
		else $error("host word reoffered at once");

	// main traffic kinds
	c_rd: cover property (is_cmd && acc && rd);
	c_wr: cover property (is_cmd && acc && !rd);
	c_stall: cover property (d2h_valid && !d2h_ready);
endmodule

`default_nettype wire

// ### test/host_transport_frame_decoder_test.sv
// bench: host end and device end joined over the word link
`timescale 1ns/1ps
`default_nettype none

module host_transport_frame_decoder_test
	import htf_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        srst;
	logic [2:0]  port_sel = 3'h4;
	logic        cmd_valid = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
	logic [15:0] cmd_word = 16'h0000, wr_data = 16'h0000;
	logic        cmd_ready, cmd_err, wr_ready, rd_valid, busy;
	logic        mem_direct, mem_we, mem_re, port_serial, port_bad;
	logic [15:0] rd_data, mem_wdata, mem_rdata, mem_idx;
	logic [14:0] mem_addr;
	logic [7:0]  page;
	logic [4:0]  cfg_opts;
	logic [2:0]  port_mode;
	logic [15:0] mem [0:65535];
	int          num_errors = 0, checked = 0, cycles = 0;

	htf_link_if link ();
	htf_dev_end htf_dev_end_i (.SYS_CLK(sys_clk), .SRST(srst),
		.LINK(link.dev), .PORT_SEL(port_sel), .MEM_ADDR(mem_addr),
		.MEM_DIRECT(mem_direct), .MEM_WE(mem_we), .MEM_RE(mem_re),
		.MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .PAGE(page),
		.CFG_OPTS(cfg_opts), .PORT_MODE(port_mode),
		.PORT_SERIAL(port_serial), .PORT_BAD(port_bad));
	htf_host_end htf_host_end_i (.SYS_CLK(sys_clk), .SRST(srst),
		.LINK(link.host), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.CMD_WORD(cmd_word), .CMD_ERR(cmd_err), .WR_VALID(wr_valid),
		.WR_READY(wr_ready), .WR_DATA(wr_data), .RD_VALID(rd_valid),
		.RD_READY(rd_ready), .RD_DATA(rd_data), .BUSY(busy));
	htf_link_props htf_link_props_i (.SYS_CLK(sys_clk), .SRST(srst),
		.h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready),
		.h2d_word(link.h2d_word), .d2h_valid(link.d2h_valid),
		.d2h_ready(link.d2h_ready), .d2h_word(link.d2h_word));

	////////////////////////////////////////////////////////////////////////
	// clock, word store with direct page above paged space, watchdog
	always #10 sys_clk = ~sys_clk;
	assign mem_idx   = {mem_direct, mem_addr};
	assign mem_rdata = mem[mem_idx];
	always @(posedge sys_clk) if (mem_we) mem[mem_idx] <= mem_wdata;
	initial for (int i = 0; i < 65536; i++) mem[i] = pat(i);
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] pat(input int i);
		return 16'(i) ^ 16'h5a5a;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// strap must stand still for several cycles before release
	task automatic do_reset(input int n);
		srst = 1'b1;
		repeat (n) @(negedge sys_clk);
		srst = 1'b0;
	endtask
	task automatic send(input logic [15:0] w, input logic err);
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_word  = w;
		while (cmd_ready !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		chk({15'h0, cmd_err}, {15'h0, err});
	endtask
	task automatic put(input logic [15:0] d);
		@(negedge sys_clk);
		wr_valid = 1'b1;
		wr_data  = d;
		while (wr_ready !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		wr_valid = 1'b0;
	endtask
	task automatic get(input logic [15:0] exp);
		@(negedge sys_clk);
		rd_ready = 1'b1;
		while (rd_valid !== 1'b1) @(negedge sys_clk);
		chk(rd_data, exp);
		@(negedge sys_clk);
		rd_ready = 1'b0;
	endtask
	// memory strobe lands a cycle after the last word leaves the host
	task automatic settle();
		repeat (2) @(negedge sys_clk);
		while (busy !== 1'b0) @(negedge sys_clk);
		repeat (3) @(negedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_straps();
		for (int s = 0; s < 8; s++) begin
			port_sel = 3'(s);
			do_reset(4);
			repeat (2) @(negedge sys_clk);
			chk({13'h0, port_mode}, {13'h0, 3'(s)});
			chk({14'h0, port_serial, port_bad}, {14'h0, s == 4, s > 4});
			chk({8'h0, page}, 16'h0000);
		end
		port_sel = 3'h4;
		do_reset(4);
		$display("test straps done");
	endtask
	// paged write that wraps past offset 127, then read back
	task automatic t_paged();
		send(16'hfe12, 1'b0);
		send(16'h7e83, 1'b0);
		for (int k = 0; k < 4; k++) put(16'hc000 + 16'(k));
		settle();
		chk({8'h0, page}, 16'h0012);
		for (int k = 0; k < 4; k++)
			chk(mem[{1'b0, 8'h12, 7'(126 + k)}], 16'hc000 + 16'(k));
		send(16'h7e03, 1'b0);
		for (int k = 0; k < 4; k++) get(16'hc000 + 16'(k));
		$display("test paged done");
	endtask
	// direct page at its top offset and with length one
	task automatic t_direct();
		send(16'hf780, 1'b0);
		put(16'hd077);
		send(16'h8581, 1'b0);
		put(16'hd005);
		put(16'hd006);
		settle();
		chk(mem[16'h8077], 16'hd077);
		chk(mem[16'h8005], 16'hd005);
		chk(mem[16'h8006], 16'hd006);
		chk({8'h0, page}, 16'h0012);
		send(16'h8501, 1'b0);
		get(16'hd005);
		get(16'hd006);
		$display("test direct done");
	endtask
	// stream writes, then a full 256-word stream read across pages
	task automatic t_stream();
		logic [15:0] e;
		send(16'hf902, 1'b0);
		for (int k = 0; k < 3; k++) put(16'he000 + 16'(k));
		send(16'hfb01, 1'b0);
		for (int k = 3; k < 5; k++) put(16'he000 + 16'(k));
		settle();
		send(16'hf8ff, 1'b0);
		for (int k = 0; k < 256; k++) begin
			e = pat(32'h900 + k);
			if (k < 5) e = 16'he000 + 16'(k);
			if (k == 126 || k == 127) e = 16'hc000 + 16'(k - 126);
			get(e);
		end
		$display("test stream done");
	endtask
	// options, no-op and refusals must not move the stream position
	task automatic t_misc();
		send(16'hfdf5, 1'b0);
		settle();
		chk({11'h0, cfg_opts}, 16'h0015);
		send(16'hffff, 1'b0);
		send(16'h80f8, 1'b1);
		send(16'hfc00, 1'b1);
		chk({8'h0, page}, 16'h0012);
		send(16'hfa00, 1'b0);
		get(pat(32'ha00));
		$display("test misc done");
	endtask

	initial begin
		do_reset(2);
		t_straps();
		t_paged();
		t_direct();
		t_stream();
		t_misc();
		print_verdict();
	end
endmodule

`default_nettype wire
